/* File: rtl/fpu_exc_unit.sv */
// Floating-point exception detection, default results and trap request.
//
// How it works
// - Exception sets cause; flag set if enable clear, else trap requested.
// - Sticky flags clear only by a software write of the control word.
// - Untrapped divide by zero delivers infinity signed from operand signs.
// - Untrapped invalid operation delivers a quiet NaN.
// - A taken trap suppresses destination write; sources untouched.
// - Inexact on rounding loss, overflow, or flushed underflow.
// - Overflow when rounded unbounded magnitude exceeds max; inexact too.
// - Untrapped overflow gives infinity or max finite by mode and sign.
// - Underflow sets U and I only if flushing allowed; otherwise E.
// - Invalid: inf-inf, zero times inf, 0/0, inf/inf, negative root.
// - Signaling NaN to arithmetic, compare or convert is invalid; copy isn't.
// - Signaling relational compare on unordered operands is invalid.
// - Divide by zero only with finite nonzero dividend and zero divisor.
// - Tininess judged on rounded result below smallest normal magnitude.
// - Loss of accuracy judged as an inexact result.
// - Reserved opcode, reserved format or bad format pairing traps E.
// - Denormal or quiet NaN operand traps E except compare and copy.
// - Out-of-range conversion to integer traps E regardless of enables.
// - Unimplemented always traps, cannot be masked, has no flag.
// - Writing zero cause bits clears every pending exception.
// - Overflow or flushed underflow sets inexact cause beside it.
`include "fpu_exc_consts.svh"
`default_nettype none
module fpu_exc_unit
   import fpu_exc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Operation being completed
   input wire logic op_valid,
   input wire logic [3:0] op_code,
   input wire logic [2:0] op_fmt,
   input wire logic [63:0] src_a,
   input wire logic [63:0] src_b,
   input wire logic [3:0] cmp_cond,
   // Datapath result and its status
   input wire logic [63:0] res_value,
   input wire logic res_sign,
   input wire logic res_inexact,
   input wire logic res_overflow,
   input wire logic res_tiny,
   input wire logic cvt_out_of_range,
   // Toward the host pipeline
   output logic exc_req,
   output logic wb_en,
   output logic [63:0] wb_data
);

   operand_class_if cls_a ();
   operand_class_if cls_b ();

   op_t op;
   fmt_t fmt;
   rmode_t rmode;

   logic [`RM_W-1:0] rmode_r;
   logic [`IEEE_W-1:0] flags_r;
   logic [`IEEE_W-1:0] enables_r;
   logic [`CAUSE_W-1:0] cause_r;
   logic flush_to_zero_r;
   logic full_reg_mode_r;
   logic exc_req_r;
   logic wb_en_r;
   logic [63:0] wb_data_r;
   logic [31:0] rdata_r;

   logic [`IEEE_W-1:0] flags_nxt;
   logic [`IEEE_W-1:0] enables_nxt;
   logic [`CAUSE_W-1:0] cause_nxt;
   logic exc_req_nxt;
   logic [31:0] rdata_nxt;

   assign op = op_t'(op_code);
   assign fmt = fmt_t'(op_fmt);
   assign rmode = rmode_t'(rmode_r);

   // Operand classes; the classifier width follows the source format.
   logic src_dbl;
   assign src_dbl = (fmt == FMT_DOUBLE);

   operand_classifier u_cls_a (
      .value(src_a),
      .dbl(src_dbl),
      .cls(cls_a)
   );

   operand_classifier u_cls_b (
      .value(src_b),
      .dbl(src_dbl),
      .cls(cls_b)
   );

   // Operation groups.
   logic is_addsub;
   logic is_arith2;
   logic is_unary;
   logic is_cvt;
   logic is_cvt_int;
   logic is_cmp;
   logic computes;
   logic rounds;
   logic two_src;
   logic fmt_float;
   logic dst_dbl;

   assign is_addsub = (op == OP_ADD) | (op == OP_SUB);
   assign is_arith2 = is_addsub | (op == OP_MUL) | (op == OP_DIV);
   assign is_unary = (op == OP_SQRT) | (op == OP_ABSOLUTE) |
                     (op == OP_NEGATE);
   assign is_cvt_int = (op == OP_TO_WORD) | (op == OP_TO_LONG);
   assign is_cvt = (op == OP_TO_SINGLE) | (op == OP_TO_DOUBLE) | is_cvt_int;
   assign is_cmp = (op == OP_COMPARE);
   assign computes = is_arith2 | is_unary | is_cvt;
   assign rounds = is_arith2 | (op == OP_SQRT) | (op == OP_TO_SINGLE) |
                   (op == OP_TO_DOUBLE);
   assign two_src = is_arith2 | is_cmp;
   assign fmt_float = (fmt == FMT_SINGLE) | (fmt == FMT_DOUBLE);
   assign dst_dbl = (op == OP_TO_DOUBLE) |
                    ((op != OP_TO_SINGLE) & src_dbl);

   logic op_known;
   logic fmt_known;
   logic bad_pairing;
   logic e_struct;

   assign op_known = (op_code <= OP_TO_LONG);
   assign fmt_known = (op_fmt <= FMT_LONG);
   assign bad_pairing = (~fmt_float & ~is_cvt) |
                        ((op == OP_TO_SINGLE) & (fmt == FMT_SINGLE)) |
                        ((op == OP_TO_DOUBLE) & (fmt == FMT_DOUBLE)) |
                        (is_cvt_int & ~fmt_float);
   assign e_struct = ~op_known | ~fmt_known | bad_pairing;

   // Operand observations, only meaningful for floating formats.
   logic snan_any;
   logic nan_any;
   logic odd_operand;

   assign snan_any = fmt_float & (cls_a.snan | (two_src & cls_b.snan));
   assign nan_any = fmt_float & (cls_a.nan | (two_src & cls_b.nan));
   assign odd_operand = fmt_float &
                        (cls_a.denorm | cls_a.quiet_nan |
                         (two_src & (cls_b.denorm | cls_b.quiet_nan)));

   // Odd operands trap for compute and convert only.
   logic e_odd;
   assign e_odd = computes & odd_operand;

   // Integer conversion range trap, enables ignored.
   logic e_range;
   assign e_range = is_cvt_int & cvt_out_of_range;

   // Tiny rounded result; its loss shows as inexact.
   logic ovf;
   logic uf;
   logic flush_ok;
   logic e_uf;

   assign ovf = rounds & res_overflow;
   assign uf = rounds & res_tiny;
   assign flush_ok = flush_to_zero_r & ~enables_r[`EXC_U] &
                     ~enables_r[`EXC_I];
   // Underflow is unimplemented unless flushing is allowed.
   assign e_uf = uf & ~flush_ok;
   logic e_any;
   assign e_any = e_struct | e_odd | e_range | e_uf;

   logic eff_sub;
   logic v_add;
   logic v_mul;
   logic v_div;
   logic v_sqrt;
   logic v_snan;
   logic v_cmp;
   logic inv;

   assign eff_sub = cls_a.sign ^ cls_b.sign ^ (op == OP_SUB);
   assign v_add = is_addsub & cls_a.inf & cls_b.inf & eff_sub;
   assign v_mul = (op == OP_MUL) &
                  ((cls_a.zero & cls_b.inf) | (cls_a.inf & cls_b.zero));
   assign v_div = (op == OP_DIV) &
                  ((cls_a.zero & cls_b.zero) | (cls_a.inf & cls_b.inf));
   assign v_sqrt = (op == OP_SQRT) & cls_a.sign & ~cls_a.zero & ~cls_a.nan;
   assign v_snan = (computes | is_cmp) & snan_any;
   assign v_cmp = is_cmp & nan_any & cmp_cond[`CMP_SIGNAL_BIT];
   assign inv = fmt_float & (v_add | v_mul | v_div | v_sqrt | v_snan | v_cmp);

   // Divide by zero with finite nonzero dividend.
   logic dz;
   assign dz = fmt_float & (op == OP_DIV) & cls_b.zero & ~cls_a.zero &
               ~cls_a.inf & ~cls_a.nan;

   logic [`IEEE_W-1:0] ieee;
   assign ieee[`EXC_I] = (rounds & res_inexact) | ovf | (uf & flush_ok);
   assign ieee[`EXC_U] = uf & flush_ok;
   assign ieee[`EXC_O] = ovf;
   assign ieee[`EXC_Z] = dz;
   assign ieee[`EXC_V] = inv;
   // Unimplemented displaces the IEEE causes and is never masked.
   logic [`CAUSE_W-1:0] new_cause;
   logic trap_now;
   logic [`IEEE_W-1:0] flag_set;
   assign new_cause = e_any ? `CAUSE_W'(1 << `EXC_E) : {1'b0, ieee};
   // Trap whenever a valid operation leaves the request set, risen or not.
   assign trap_now = op_valid & exc_req_nxt;
   assign flag_set = (op_valid & ~e_any) ? (ieee & ~enables_r) : `IEEE_RST;

   // Default results for the destination format.
   function automatic logic [63:0] fmt_value(
      input logic dbl,
      input logic sgn,
      input logic [63:0] dval,
      input logic [31:0] sval
   );
      logic [63:0] v;
      v = dbl ? dval : {{32{1'b0}}, sval};
      if (dbl) begin
         v[`DBL_SIGN] = sgn;
      end else begin
         v[`SGL_SIGN] = sgn;
      end
      return v;
   endfunction

   logic dz_sign;
   logic ovf_to_inf;
   logic uf_to_min;
   logic [63:0] quiet_nan_val;
   logic [63:0] dz_val;
   logic [63:0] ovf_val;
   logic [63:0] uf_val;
   logic [63:0] deliver;

   assign dz_sign = cls_a.sign ^ cls_b.sign;
   // Overflow target from rounding mode and sign.
   assign ovf_to_inf = (rmode == RM_NEAREST) |
                       ((rmode == RM_PLUS) & ~res_sign) |
                       ((rmode == RM_MINUS) & res_sign);
   assign uf_to_min = ((rmode == RM_PLUS) & ~res_sign) |
                      ((rmode == RM_MINUS) & res_sign);
   // Quiet NaN carries a clear fraction MSB here.
   assign quiet_nan_val = fmt_value(dst_dbl, 1'b0, `DBL_QUIET_NAN,
                                    `SGL_QUIET_NAN);
   assign dz_val = fmt_value(dst_dbl, dz_sign, `DBL_INF, `SGL_INF);
   assign ovf_val = ovf_to_inf ?
                    fmt_value(dst_dbl, res_sign, `DBL_INF, `SGL_INF) :
                    fmt_value(dst_dbl, res_sign, `DBL_MAX, `SGL_MAX);
   assign uf_val = uf_to_min ?
                   fmt_value(dst_dbl, res_sign, `DBL_MIN_SUB, `SGL_MIN_SUB) :
                   fmt_value(dst_dbl, res_sign, `DBL_ZERO, `SGL_ZERO);
   assign deliver = inv ? quiet_nan_val :
                    dz ? dz_val :
                    ovf ? ovf_val :
                    uf ? uf_val :
                    res_value;

   // Register decode.
   logic csr_wr;
   logic mode_wr;
   logic [31:0] csr_word;
   logic [31:0] mode_word;

   assign csr_wr = reg_wr & (reg_addr == `CSR_ADDR);
   assign mode_wr = reg_wr & (reg_addr == `MODE_ADDR);

   always_comb begin
      csr_word = `WORD_ZERO;
      csr_word[`CSR_RM_LO +: `RM_W] = rmode_r;
      csr_word[`CSR_FLAG_LO +: `IEEE_W] = flags_r;
      csr_word[`CSR_EN_LO +: `IEEE_W] = enables_r;
      csr_word[`CSR_CAUSE_LO +: `CAUSE_W] = cause_r;
      csr_word[`CSR_FLUSH_BIT] = flush_to_zero_r;
      mode_word = `WORD_ZERO;
      mode_word[`MODE_FULL_REG_BIT] = full_reg_mode_r;
   end

   assign rdata_nxt = ~reg_rd ? `WORD_ZERO :
                      (reg_addr == `CSR_ADDR) ? csr_word :
                      (reg_addr == `MODE_ADDR) ? mode_word :
                      `WORD_ZERO;

   // Only a control write lowers a flag; a same-cycle event wins.
   assign flags_nxt = (csr_wr ? reg_wdata[`CSR_FLAG_LO +: `IEEE_W] : flags_r) |
                      flag_set;
   assign enables_nxt = csr_wr ? reg_wdata[`CSR_EN_LO +: `IEEE_W] : enables_r;

   // Each operation replaces the cause field; a colliding write merges in.
   logic [`CAUSE_W-1:0] op_cause;
   assign op_cause = op_valid ? new_cause : `CAUSE_RST;
   assign cause_nxt = csr_wr ?
                      (reg_wdata[`CSR_CAUSE_LO +: `CAUSE_W] | op_cause) :
                      (op_valid ? new_cause : cause_r);

   // Request follows pending causes, so writing zero cause drops it.
   assign exc_req_nxt = cause_nxt[`EXC_E] |
                        (|(cause_nxt[`IEEE_W-1:0] & enables_nxt));

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rmode_r <= `RM_RST;
         flush_to_zero_r <= 1'b0;
         full_reg_mode_r <= 1'b0;
      end else begin
         if (csr_wr) begin
            rmode_r <= reg_wdata[`CSR_RM_LO +: `RM_W];
            flush_to_zero_r <= reg_wdata[`CSR_FLUSH_BIT];
         end
         if (mode_wr) begin
            full_reg_mode_r <= reg_wdata[`MODE_FULL_REG_BIT];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_r <= `IEEE_RST;
         enables_r <= `IEEE_RST;
         cause_r <= `CAUSE_RST;
         exc_req_r <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         enables_r <= enables_nxt;
         cause_r <= cause_nxt;
         exc_req_r <= exc_req_nxt;
      end
   end

   // The old destination value is held on a trap, never overwritten.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wb_en_r <= 1'b0;
         wb_data_r <= `DWORD_ZERO;
         rdata_r <= `WORD_ZERO;
      end else begin
         // No writeback when the trap is taken.
         wb_en_r <= op_valid & ~trap_now & ~is_cmp;
         if (op_valid & ~trap_now & ~is_cmp) begin
            wb_data_r <= deliver;
         end
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign exc_req = exc_req_r;
   assign wb_en = wb_en_r;
   assign wb_data = wb_data_r;
endmodule
`default_nettype wire

/* File: pkg/fpu_exc_consts.svh */
// Offsets, field positions, reset values and format constants for the FPU exception unit.
`ifndef FPU_EXC_CONSTS_SVH
`define FPU_EXC_CONSTS_SVH

`define REG_ADDR_W 4
`define CSR_ADDR 4'h0
`define MODE_ADDR 4'h4

`define RM_W 2
`define IEEE_W 5
`define CAUSE_W 6
`define CSR_RM_LO 0
`define CSR_FLAG_LO 2
`define CSR_EN_LO 7
`define CSR_CAUSE_LO 12
`define CSR_FLUSH_BIT 24
`define MODE_FULL_REG_BIT 0

`define EXC_I 0
`define EXC_U 1
`define EXC_O 2
`define EXC_Z 3
`define EXC_V 4
`define EXC_E 5

`define RM_RST 2'h0
`define IEEE_RST 5'h00
`define CAUSE_RST 6'h00
`define WORD_ZERO 32'h0000_0000
`define DWORD_ZERO 64'h0000_0000_0000_0000

`define CMP_SIGNAL_BIT 3

`define SGL_SIGN 31
`define SGL_EXP_HI 30
`define SGL_EXP_LO 23
`define SGL_FRAC_MSB 22
`define SGL_FRAC_LO 0
`define DBL_SIGN 63
`define DBL_EXP_HI 62
`define DBL_EXP_LO 52
`define DBL_FRAC_MSB 51
`define DBL_FRAC_LO 0

`define SGL_INF 32'h7f80_0000
`define SGL_MAX 32'h7f7f_ffff
`define SGL_MIN_SUB 32'h0000_0001
`define SGL_ZERO 32'h0000_0000
`define SGL_QUIET_NAN 32'h7fbf_ffff
`define DBL_INF 64'h7ff0_0000_0000_0000
`define DBL_MAX 64'h7fef_ffff_ffff_ffff
`define DBL_MIN_SUB 64'h0000_0000_0000_0001
`define DBL_ZERO 64'h0000_0000_0000_0000
`define DBL_QUIET_NAN 64'h7ff7_ffff_ffff_ffff

`endif

/* File: pkg/fpu_exc_pkg.sv */
// Types shared by the FPU exception unit and its operand classifier.
`default_nettype none
package fpu_exc_pkg;

   typedef enum logic [3:0] {
      OP_ADD       = 4'h0,
      OP_SUB       = 4'h1,
      OP_MUL       = 4'h2,
      OP_DIV       = 4'h3,
      OP_SQRT      = 4'h4,
      OP_ABSOLUTE  = 4'h5,
      OP_NEGATE    = 4'h6,
      OP_REG_COPY  = 4'h7,
      OP_COMPARE   = 4'h8,
      OP_TO_SINGLE = 4'h9,
      OP_TO_DOUBLE = 4'ha,
      OP_TO_WORD   = 4'hb,
      OP_TO_LONG   = 4'hc
   } op_t;

   typedef enum logic [2:0] {
      FMT_SINGLE = 3'h0,
      FMT_DOUBLE = 3'h1,
      FMT_WORD   = 3'h2,
      FMT_LONG   = 3'h3
   } fmt_t;

   typedef enum logic [1:0] {
      RM_NEAREST = 2'h0,
      RM_ZERO    = 2'h1,
      RM_PLUS    = 2'h2,
      RM_MINUS   = 2'h3
   } rmode_t;

endpackage
`default_nettype wire

/* File: pkg/operand_class_if.sv */
// Classification of one floating-point operand, from classifier to exception logic.
`default_nettype none
interface operand_class_if;
   logic sign;
   logic zero;
   logic inf;
   logic nan;
   logic snan;
   logic quiet_nan;
   logic denorm;

   modport src (
      output sign,
      output zero,
      output inf,
      output nan,
      output snan,
      output quiet_nan,
      output denorm
   );

   modport dst (
      input sign,
      input zero,
      input inf,
      input nan,
      input snan,
      input quiet_nan,
      input denorm
   );
endinterface
`default_nettype wire

/* File: rtl/operand_classifier.sv */
// Splits a single or double operand into zero, infinity, NaN and denormal classes.
`include "fpu_exc_consts.svh"
`default_nettype none
module operand_classifier
   import fpu_exc_pkg::*;
(
   // Operand and its width
   input wire logic [63:0] value,
   input wire logic dbl,
   // Class of the operand
   operand_class_if.src cls
);

   logic exp_ones;
   logic exp_zero;
   logic frac_zero;
   logic frac_msb;

   assign exp_ones = dbl ? &value[`DBL_EXP_HI:`DBL_EXP_LO]
                         : &value[`SGL_EXP_HI:`SGL_EXP_LO];
   assign exp_zero = dbl ? ~|value[`DBL_EXP_HI:`DBL_EXP_LO]
                         : ~|value[`SGL_EXP_HI:`SGL_EXP_LO];
   assign frac_zero = dbl ? ~|value[`DBL_FRAC_MSB:`DBL_FRAC_LO]
                          : ~|value[`SGL_FRAC_MSB:`SGL_FRAC_LO];
   assign frac_msb = dbl ? value[`DBL_FRAC_MSB] : value[`SGL_FRAC_MSB];

   assign cls.sign = dbl ? value[`DBL_SIGN] : value[`SGL_SIGN];
   assign cls.zero = exp_zero & frac_zero;
   assign cls.denorm = exp_zero & ~frac_zero;
   assign cls.inf = exp_ones & frac_zero;
   assign cls.nan = exp_ones & ~frac_zero;
   // In this number system a set fraction MSB marks the signaling kind.
   assign cls.snan = exp_ones & ~frac_zero & frac_msb;
   assign cls.quiet_nan = exp_ones & ~frac_zero & ~frac_msb;

endmodule
`default_nettype wire

/* File: sim/host_pipe_model.sv */
// Host pipeline stand-in: retires writebacks and takes coprocessor traps.
`default_nettype none
module host_pipe_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // From the exception unit
   input wire logic exc_req,
   input wire logic wb_en,
   input wire logic [63:0] wb_data,
   input wire logic full_reg,
   // Observed state
   output logic [63:0] dest_r,
   output logic [7:0] trap_cnt_r,
   output logic [5:0] save_words
);
   timeunit 1ns;
   timeprecision 1ps;
   logic req_d_r;
   assign save_words = full_reg ? 6'h20 : 6'h10;
   // The destination moves only on a writeback, so a trap leaves it intact.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         dest_r <= 64'h0;
         trap_cnt_r <= 8'h00;
         req_d_r <= 1'b0;
      end else begin
         req_d_r <= exc_req;
         if (wb_en)
            dest_r <= wb_data;
         if (exc_req && !req_d_r)
            trap_cnt_r <= trap_cnt_r + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* File: sim/fpu_exc_unit_monitor.sv */
// Port-level checks of default results and trap requests.
`include "fpu_exc_consts.svh"
`default_nettype none
module fpu_exc_unit_monitor
   import fpu_exc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   // Operation and status
   input wire logic op_valid,
   input wire logic [3:0] op_code,
   input wire logic [2:0] op_fmt,
   input wire logic [63:0] src_a,
   input wire logic [63:0] src_b,
   input wire logic res_tiny,
   input wire logic cvt_out_of_range,
   // Toward the host
   input wire logic exc_req,
   input wire logic wb_en,
   input wire logic [63:0] wb_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Shadow of "flushing allowed"; an op sees the value before its edge.
   logic flush_ok_r;
   logic flush_ok_nxt;
   wire logic csr_wr = reg_wr && reg_addr == `CSR_ADDR;
   wire logic a_fin = src_a[62:52] != 11'h000 && src_a[62:52] != 11'h7ff;
   wire logic b_zero = src_b[62:0] == 63'h0;
   wire logic dbl_op = op_valid && op_fmt == FMT_DOUBLE;
   wire logic q_sign = src_a[63] ^ src_b[63];
   wire logic [1:0] ui_en = reg_wdata[`CSR_EN_LO+1:`CSR_EN_LO];
   assign flush_ok_nxt = csr_wr ?
      (reg_wdata[`CSR_FLUSH_BIT] && ui_en == 2'h0) : flush_ok_r;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         flush_ok_r <= 1'b0;
      else
         flush_ok_r <= flush_ok_nxt;
   end
   property p_div_zero;
      dbl_op && op_code == OP_DIV && a_fin && b_zero |=> exc_req ||
         (wb_en && wb_data == {$past(q_sign), 11'h7ff, 52'h0});
   endproperty
   a_div_zero: assert property (p_div_zero)
      else $error("divide by zero result wrong");
   property p_zero_inf;
      dbl_op && op_code == OP_MUL && src_a[62:0] == 63'h0 &&
         src_b[62:0] == 63'h7ff0_0000_0000_0000
      |=> exc_req || (wb_en && wb_data == `DBL_QUIET_NAN);
   endproperty
   a_zero_inf: assert property (p_zero_inf)
      else $error("zero times infinity not quiet nan");
   property p_trap_no_wb;
      exc_req && $past(op_valid) |-> !wb_en;
   endproperty
   a_trap_no_wb: assert property (p_trap_no_wb)
      else $error("writeback during trap");
   property p_copy;
      op_valid && op_code == OP_REG_COPY && op_fmt <= FMT_DOUBLE && !reg_wr
      |=> wb_en && !exc_req;
   endproperty
   a_copy: assert property (p_copy)
      else $error("register copy trapped");
   property p_reserved;
      op_valid && (op_code > 4'hc || op_fmt > 3'h3) |=> exc_req && !wb_en;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved code did not trap");
   property p_cvt_range;
      op_valid && (op_code == OP_TO_WORD || op_code == OP_TO_LONG) &&
         cvt_out_of_range |=> exc_req && !wb_en;
   endproperty
   a_cvt_range: assert property (p_cvt_range)
      else $error("out of range convert did not trap");
   property p_unf_trap;
      dbl_op && op_code == OP_ADD && res_tiny && !flush_ok_r
      |=> exc_req && !wb_en;
   endproperty
   a_unf_trap: assert property (p_unf_trap)
      else $error("unflushed underflow did not trap");
   property p_cause_clear;
      csr_wr && reg_wdata[`CSR_CAUSE_LO+5:`CSR_CAUSE_LO] == 6'h00 &&
         !op_valid |=> !exc_req;
   endproperty
   a_cause_clear: assert property (p_cause_clear)
      else $error("request stayed after cause cleared");
   property p_req_stands;
      exc_req && !reg_wr && !op_valid |=> exc_req;
   endproperty
   a_req_stands: assert property (p_req_stands)
      else $error("request dropped on its own");
   property p_wb_clean;
      wb_en |-> !exc_req && $past(op_valid);
   endproperty
   a_wb_clean: assert property (p_wb_clean)
      else $error("writeback without clean operation");
endmodule
bind fpu_exc_unit fpu_exc_unit_monitor mon (.ref_clk(ref_clk),
   .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .op_valid(op_valid), .op_code(op_code),
   .op_fmt(op_fmt), .src_a(src_a), .src_b(src_b), .res_tiny(res_tiny),
   .cvt_out_of_range(cvt_out_of_range), .exc_req(exc_req), .wb_en(wb_en),
   .wb_data(wb_data));
`default_nettype wire

/* File: sim/fpu_exc_unit_tb.sv */
// Self-checking bench for the floating-point exception unit.
`include "fpu_exc_consts.svh"
`default_nettype none
module fpu_exc_unit_tb
   import fpu_exc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [63:0] ONE = 64'h3ff0_0000_0000_0000;
   localparam logic [63:0] TWO = 64'h4000_0000_0000_0000;
   localparam logic [63:0] NINF = 64'hfff0_0000_0000_0000;
   localparam logic [63:0] SN = 64'h7ff8_0000_0000_0001;
   localparam logic [63:0] QA = 64'h7ff0_0000_0000_0001;
   localparam logic [63:0] SQ = {32'h0, `SGL_QUIET_NAN};
   logic ref_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, op_valid = 0;
   logic [3:0] reg_addr = 4'h0, op_code = 4'h0, cmp_cond = 4'h8;
   logic [2:0] op_fmt = 3'h1;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [63:0] src_a = 64'h0, src_b = 64'h0, wb_data, dest_r;
   logic [4:0] st = 5'h00;
   logic exc_req, wb_en, full_reg = 0;
   logic [7:0] trap_cnt;
   logic [5:0] save_words;
   int miscompares = 0, compares = 0;
   logic [3:0] vc [9] = '{OP_ADD, OP_MUL, OP_DIV, OP_DIV, OP_SQRT,
      OP_ABSOLUTE, OP_COMPARE, OP_NEGATE, OP_MUL};
   logic [63:0] va [9] = '{`DBL_INF, 64'h0, 64'h0, `DBL_INF,
      64'hbff0_0000_0000_0000, SN, QA, SN, 64'h0};
   logic [63:0] vb [9] = '{NINF, `DBL_INF, 64'h0, NINF, 64'h0, 64'h0,
      ONE, 64'h0, {32'h0, `SGL_INF}};
   logic [31:0] uc [3] = '{32'h0100_0002, 32'h0000_0002, 32'h0100_0082};
   logic [31:0] ue [3] = '{32'h0100_300e, 32'h0002_0002, 32'h0102_0082};
   logic [3:0] ec [6] = '{4'hd, OP_ADD, OP_TO_SINGLE, OP_TO_WORD, OP_ADD,
      OP_MUL};
   logic [2:0] ef [6] = '{3'h1, 3'h5, 3'h0, 3'h1, 3'h1, 3'h1};
   logic [63:0] ea [6] = '{ONE, ONE, 64'h3f80_0000, ONE, `DBL_MIN_SUB, QA};
   fpu_exc_unit uut (.ref_clk(ref_clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
      .op_code(op_code), .op_fmt(op_fmt), .src_a(src_a), .src_b(src_b),
      .cmp_cond(cmp_cond), .res_value(TWO), .res_sign(st[0]),
      .res_inexact(st[1]), .res_overflow(st[2]), .res_tiny(st[3]),
      .cvt_out_of_range(st[4]), .exc_req(exc_req), .wb_en(wb_en),
      .wb_data(wb_data));
   host_pipe_model host (.ref_clk(ref_clk), .arst_n(arst_n),
      .exc_req(exc_req), .wb_en(wb_en), .wb_data(wb_data),
      .full_reg(full_reg), .dest_r(dest_r), .trap_cnt_r(trap_cnt),
      .save_words(save_words));
   always #4 ref_clk = ~ref_clk;
   task automatic check(input string n, input logic [63:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 check("reg_rdata", {32'h0, reg_rdata}, {32'h0, e});
   endtask
   // Status bits: {out of range, tiny, overflow, inexact, sign}.
   task automatic op(input logic [3:0] c, input logic [2:0] f,
      input logic [63:0] a, b, input logic [4:0] s);
      @(posedge ref_clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_fmt <= f;
      src_a <= a;
      src_b <= b;
      st <= s;
      @(posedge ref_clk);
      op_valid <= 1'b0;
      st <= 5'h00;
      #1;
   endtask
   task automatic res(input logic e, q, input logic [63:0] d);
      check("wb_en", {63'h0, wb_en}, {63'h0, e});
      check("exc_req", {63'h0, exc_req}, {63'h0, q});
      check("wb_data", wb_data, d);
   endtask
   function automatic logic [63:0] ovf(input logic [1:0] m, input logic s);
      logic big;
      big = m == 2'h0 || (m == 2'h2 && !s) || (m == 2'h3 && s);
      return {s, big ? 63'h7ff0_0000_0000_0000 : 63'h7fef_ffff_ffff_ffff};
   endfunction
   task automatic stop_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(4'h0, 32'h0);
      wr(4'h8, 32'hffff_ffff);
      rd(4'h8, 32'h0);
      wr(4'h4, 32'h1);
      full_reg = 1'b1;
      rd(4'h4, 32'h1);
      check("save_words", {58'h0, save_words}, 64'h20);
      $display("test registers done");
      op(OP_DIV, FMT_DOUBLE, ONE, 64'h8000_0000_0000_0000, 5'h00);
      res(1, 0, NINF);
      rd(4'h0, 32'h0000_8020);
      op(OP_ADD, FMT_DOUBLE, ONE, ONE, 5'h00);
      res(1, 0, TWO);
      rd(4'h0, 32'h0000_0020);
      wr(4'h0, 32'h0000_0400);
      op(OP_DIV, FMT_DOUBLE, ONE, 64'h0, 5'h00);
      res(0, 1, TWO);
      check("dest", dest_r, TWO);
      rd(4'h0, 32'h0000_8400);
      wr(4'h0, 32'h0000_0400);
      check("exc_req", {63'h0, exc_req}, 64'h0);
      $display("test divide done");
      for (int i = 0; i < 9; i++) begin
         wr(4'h0, 32'h0);
         op(vc[i], i == 8 ? 3'h0 : 3'h1, va[i], vb[i], 5'h00);
         res(vc[i] != OP_COMPARE, 0, i == 8 ? SQ : `DBL_QUIET_NAN);
         rd(4'h0, 32'h0001_0040);
      end
      $display("test invalid done");
      for (int m = 0; m < 8; m++) begin
         wr(4'h0, {30'h0, m[1:0]});
         op(OP_ADD, FMT_DOUBLE, ONE, ONE, {4'h3, m[2]});
         res(1, 0, ovf(m[1:0], m[2]));
         rd(4'h0, {30'h0, m[1:0]} | 32'h0000_5014);
      end
      $display("test overflow done");
      for (int k = 0; k < 3; k++) begin
         wr(4'h0, uc[k]);
         op(OP_ADD, FMT_DOUBLE, ONE, ONE, 5'h08);
         res(k == 0, k != 0, `DBL_MIN_SUB);
         rd(4'h0, ue[k]);
      end
      wr(4'h0, 32'h0);
      op(OP_ADD, FMT_DOUBLE, ONE, ONE, 5'h02);
      res(1, 0, TWO);
      rd(4'h0, 32'h0000_1004);
      $display("test underflow done");
      for (int j = 0; j < 6; j++) begin
         wr(4'h0, 32'h0000_0800);
         op(ec[j], ef[j], ea[j], ONE, j == 3 ? 5'h10 : 5'h00);
         res(0, 1, TWO);
         rd(4'h0, 32'h0002_0800);
      end
      wr(4'h0, 32'h0000_0800);
      cmp_cond <= 4'h0;
      op(OP_COMPARE, FMT_DOUBLE, QA, `DBL_MIN_SUB, 5'h00);
      res(0, 0, TWO);
      op(OP_REG_COPY, FMT_DOUBLE, QA, ONE, 5'h00);
      check("wb_en", {63'h0, wb_en}, 64'h1);
      check("trap_cnt", {56'h0, trap_cnt}, 64'h9);
      $display("test unimplemented done");
      stop_test;
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      miscompares++;
      stop_test;
   end
endmodule
`default_nettype wire
